/* File: logic/asfc_pkg.sv */
package asfc_pkg;

   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int DEPTH    = 32;
   localparam int SAMPLE_W = 48;
   localparam int LEVEL_W  = 6;
   localparam int SEQ_W    = 4;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_AXIS_FIRST = 8'h32;
   localparam logic [7:0] ADDR_AXIS_LAST  = 8'h37;
   localparam logic [7:0] ADDR_BUF_CTRL   = 8'h38;
   localparam logic [7:0] ADDR_BUF_STATUS = 8'h39;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int CTRL_MODE_HI    = 7;
   localparam int CTRL_MODE_LO    = 6;
   localparam int CTRL_TRIG_SEL   = 5;
   localparam int CTRL_SAMPLES_HI = 4;
   localparam int STAT_TRIG_FIRED = 7;
   localparam int STAT_LEVEL_HI   = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int HOST_GAP_NS    = 5000;
   localparam int CORE_PERIOD_NS = 50;
   localparam int HOST_GAP_CYC   = (HOST_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_BYPASS = 2'h0,
      MODE_FILL   = 2'h1,
      MODE_STREAM = 2'h2,
      MODE_TRIG   = 2'h3
   } asfc_mode_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_TRIM = 3'h2,
      ST_HOLD = 3'h4
   } asfc_trig_type;

endpackage

/* File: logic/asfc_sample_buffer.sv */
`timescale 1ns/1ps
module asfc_sample_buffer #(
   parameter int DEPTH_P = asfc_pkg::DEPTH
) (
   // core clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          reset,
   // measurement input
   input  wire logic                          smp_valid,
   input  wire logic [asfc_pkg::SAMPLE_W-1:0] smp_data,
   // trigger sources
   input  wire logic                          irq_out_a,
   input  wire logic                          irq_out_b,
   // host register access, link domain
   input  wire logic                          link_clk,
   input  wire logic                          cs_n,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [7:0]                    reg_wdata,
   output logic      [7:0]                    reg_rdata,
   // status flags
   output logic                               watermark,
   output logic                               overrun,
   output logic                               data_ready,
   output logic      [asfc_pkg::LEVEL_W-1:0]  level
);
   import asfc_pkg::*;

   generate
      if (DEPTH_P < 2 || DEPTH_P > 62) begin : g_chk_depth
         $error("asfc_sample_buffer: DEPTH_P out of range");
      end
      if (DEPTH_P + 2 > HOST_GAP_CYC) begin : g_chk_gap
         $error("asfc_sample_buffer: trim cannot finish within host wait");
      end
   endgenerate

   localparam logic [LEVEL_W-1:0] FULL_LVL = LEVEL_W'(DEPTH_P);
   localparam int PTR_W = $clog2(DEPTH_P);

   // ----------------------------------------
   // link domain: registers seen by the host
   // ----------------------------------------
   logic [7:0]          ctrl_r;
   logic [SEQ_W-1:0]    touch_seq_r;
   logic [SEQ_W-1:0]    pop_seq_r;
   logic [7:0]          last_rd_r;
   logic [SAMPLE_W+7:0] core_view;

   wire is_axis   = (reg_addr >= ADDR_AXIS_FIRST) && (reg_addr <= ADDR_AXIS_LAST);
   wire addr_pop  = reg_rd && (reg_addr == ADDR_BUF_CTRL) && (last_rd_r == ADDR_AXIS_LAST);
   wire [2:0] byte_sel = 3'(reg_addr - ADDR_AXIS_FIRST);
   wire [7:0] axis_byte = core_view[SAMPLE_W+7-8*byte_sel -: 8];
   wire [7:0] rd_mux = is_axis ? axis_byte :
                       (reg_addr == ADDR_BUF_CTRL)   ? ctrl_r :
                       (reg_addr == ADDR_BUF_STATUS) ? core_view[7:0] : 8'h00;

   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         ctrl_r      <= CTRL_RESET;
         touch_seq_r <= '0;
         pop_seq_r   <= '0;
         last_rd_r   <= 8'h00;
         reg_rdata   <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == ADDR_BUF_CTRL) begin
            ctrl_r <= reg_wdata;
         end
         if (reg_rd) begin
            reg_rdata <= rd_mux;
            last_rd_r <= reg_addr;
         end
         if (reg_rd && is_axis) begin
            touch_seq_r <= touch_seq_r + 1'b1;
         end
         if (addr_pop) begin
            pop_seq_r <= pop_seq_r + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // crossings
   // ----------------------------------------
   logic [7+2*SEQ_W:0]  link_bundle;
   logic [SAMPLE_W+7:0] core_bundle;

   asfc_word_xfer #(.WIDTH(8 + 2*SEQ_W)) u_to_core (
      .src_clk  (link_clk),
      .src_data ({ctrl_r, touch_seq_r, pop_seq_r}),
      .dst_clk  (core_clk),
      .dst_data (link_bundle),
      .reset    (reset)
   );

   asfc_word_xfer #(.WIDTH(SAMPLE_W + 8)) u_to_link (
      .src_clk  (core_clk),
      .src_data (core_bundle),
      .dst_clk  (link_clk),
      .dst_data (core_view),
      .reset    (reset)
   );

   // ----------------------------------------
   // core: control decode
   // ----------------------------------------
   wire [7:0]       ctrl      = link_bundle[7+2*SEQ_W -: 8];
   wire [SEQ_W-1:0] touch_seq = link_bundle[2*SEQ_W-1 -: SEQ_W];
   wire [SEQ_W-1:0] pop_seq   = link_bundle[SEQ_W-1:0];
   wire asfc_mode_type mode   = asfc_mode_type'(ctrl[CTRL_MODE_HI:CTRL_MODE_LO]);
   wire [LEVEL_W-1:0] thresh  = LEVEL_W'(ctrl[CTRL_SAMPLES_HI:0]);
   wire bypass_w = (mode == MODE_BYPASS);

   // ----------------------------------------
   // core: pop detection
   // ----------------------------------------
   logic [2:0]       cs_sync_r;
   logic             cs_stable_r;
   logic [SEQ_W-1:0] touch_seen_r;
   logic [SEQ_W-1:0] pop_seen_r;
   logic             touched_r;

   wire cs_agree  = (cs_sync_r[1] == cs_sync_r[2]);
   wire cs_rise   = cs_agree && cs_sync_r[2] && !cs_stable_r;
   wire touch_chg = (touch_seq != touch_seen_r);
   wire pop_ev    = (pop_seq != pop_seen_r) || (cs_rise && (touched_r || touch_chg));

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cs_sync_r    <= 3'h7;
         cs_stable_r  <= 1'b1;
         touch_seen_r <= '0;
         pop_seen_r   <= '0;
         touched_r    <= 1'b0;
      end else begin
         cs_sync_r    <= {cs_sync_r[1:0], cs_n};
         touch_seen_r <= touch_seq;
         pop_seen_r   <= pop_seq;
         touched_r    <= pop_ev ? 1'b0 : (touched_r || touch_chg);
         if (cs_agree) begin
            cs_stable_r <= cs_sync_r[2];
         end
      end
   end

   // ----------------------------------------
   // core: storage and flags
   // ----------------------------------------
   logic [SAMPLE_W-1:0] mem [DEPTH_P];
   logic [SAMPLE_W-1:0] axis_r;
   logic [PTR_W-1:0]    wr_ptr_r;
   logic [PTR_W-1:0]    rd_ptr_r;
   logic [LEVEL_W-1:0]  count_r;
   logic                unread_r;
   logic                bp_was_r;
   logic                wm_r;
   logic                ovr_r;
   asfc_trig_type       st_r;
   asfc_trig_type       st_nxt;

   // unread axis data from the other side of a change into or out of bypass is stale
   wire keep_unread = unread_r && !pop_ev && (bp_was_r == bypass_w);
   wire [LEVEL_W-1:0] level_w  = count_r + LEVEL_W'(unread_r && !bypass_w);
   wire full_w     = (level_w == FULL_LVL);
   wire ovw_mode   = (mode == MODE_STREAM) || (mode == MODE_TRIG && st_r == ST_IDLE);
   wire trig_ev    = (mode == MODE_TRIG) && (st_r == ST_IDLE) &&
                     (ctrl[CTRL_TRIG_SEL] ? irq_out_b : irq_out_a);
   wire trim_drop  = (st_r == ST_TRIM) && (level_w > thresh) && !pop_ev;
   wire ovw        = smp_valid && full_w && ovw_mode && !pop_ev;
   wire wr_en      = !bypass_w && smp_valid && (!full_w || pop_ev || ovw_mode);
   wire head_load  = !bypass_w && (count_r != 0) &&
                     (!unread_r || pop_ev || ovw || trim_drop);
   wire unread_nxt = bypass_w ? (smp_valid || keep_unread) :
                     head_load ? 1'b1 : (keep_unread && !trim_drop);
   wire [LEVEL_W-1:0] count_nxt = bypass_w ? '0 :
                     LEVEL_W'(count_r + LEVEL_W'(wr_en) - LEVEL_W'(head_load));
   wire [LEVEL_W-1:0] level_nxt = count_nxt + LEVEL_W'(unread_nxt);
   wire ovr_set_bp = bypass_w && smp_valid && unread_r && !pop_ev;
   wire ovr_set_nb = !bypass_w && (level_nxt == FULL_LVL) && !full_w;
   wire ovr_set    = ovr_set_bp || ovr_set_nb;

   // trigger capture sequence
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE: begin
            if (trig_ev) begin
               st_nxt = ST_TRIM;
            end
         end
         ST_TRIM: begin
            if (level_w <= thresh) begin
               st_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            st_nxt = ST_HOLD;
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      if (mode != MODE_TRIG) begin
         st_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_ptr_r] <= smp_data;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         axis_r   <= '0;
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         unread_r <= 1'b0;
         bp_was_r <= 1'b1;
         wm_r     <= 1'b0;
         ovr_r    <= 1'b0;
         st_r     <= ST_IDLE;
      end else begin
         st_r     <= st_nxt;
         count_r  <= count_nxt;
         unread_r <= unread_nxt;
         bp_was_r <= bypass_w;
         ovr_r    <= ovr_set || (ovr_r && !pop_ev);
         wm_r     <= (level_w == thresh) || (wm_r && level_w >= thresh);
         if (bypass_w) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            if (smp_valid) begin
               axis_r <= smp_data;
            end
         end else begin
            if (wr_en) begin
               wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH_P - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (head_load) begin
               axis_r   <= mem[rd_ptr_r];
               rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH_P - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // core: outputs
   // ----------------------------------------
   wire [7:0] status_byte = {(st_r != ST_IDLE), 1'b0, level_w};
   assign core_bundle = {axis_r, status_byte};
   assign watermark   = wm_r;
   assign overrun     = ovr_r;
   assign data_ready  = (level_w != 0) || (bypass_w && unread_r);
   assign level       = level_w;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_wm_set;
      @(posedge core_clk) disable iff (reset)
      (level_w == thresh) |=> watermark;
   endproperty
   a_wm_set: assert property (p_wm_set) else $error("watermark missed at threshold");

   property p_wm_clr;
      @(posedge core_clk) disable iff (reset)
      (level_w < thresh) |=> !watermark;
   endproperty
   a_wm_clr: assert property (p_wm_clr) else $error("watermark held below threshold");

   property p_ovr_bypass;
      @(posedge core_clk) disable iff (reset)
      (bypass_w && smp_valid && unread_r && !pop_ev) |=> overrun;
   endproperty
   a_ovr_bypass: assert property (p_ovr_bypass) else $error("bypass overrun missed");

   property p_ovr_fill;
      @(posedge core_clk) disable iff (reset)
      (!bypass_w && !full_w) ##1 (level_w == FULL_LVL) |-> overrun;
   endproperty
   a_ovr_fill: assert property (p_ovr_fill) else $error("fill overrun missed");

   property p_ovr_clr;
      @(posedge core_clk) disable iff (reset)
      (pop_ev && !ovr_set) |=> !overrun;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared by read");

   property p_depth;
      @(posedge core_clk) disable iff (reset)
      level_w <= FULL_LVL;
   endproperty
   a_depth: assert property (p_depth) else $error("level above depth");

   property p_bypass_empty;
      @(posedge core_clk) disable iff (reset)
      bypass_w[*2] |-> (count_r == 0) && (wr_ptr_r == rd_ptr_r);
   endproperty
   a_bypass_empty: assert property (p_bypass_empty) else $error("bypass left data");

   property p_fill_stop;
      @(posedge core_clk) disable iff (reset)
      (mode == MODE_FILL && full_w && !pop_ev) |=> $stable(wr_ptr_r);
   endproperty
   a_fill_stop: assert property (p_fill_stop) else $error("fill mode wrote when full");

   property p_trim_done;
      @(posedge core_clk) disable iff (reset)
      $rose(st_r == ST_TRIM) |-> ##[1:40] (st_r != ST_TRIM);
   endproperty
   a_trim_done: assert property (p_trim_done) else $error("trigger trim too long");

   property p_one_trigger;
      @(posedge core_clk) disable iff (reset)
      (st_r == ST_HOLD && mode == MODE_TRIG) |=> (st_r == ST_HOLD);
   endproperty
   a_one_trigger: assert property (p_one_trigger) else $error("trigger rearmed");

   property p_cs_pop;
      @(posedge core_clk) disable iff (reset)
      (cs_rise && touched_r && !bypass_w && count_r != 0) |=> unread_r;
   endproperty
   a_cs_pop: assert property (p_cs_pop) else $error("cs release did not pop");

endmodule

/* File: logic/asfc_word_xfer.sv */
`timescale 1ns/1ps
module asfc_word_xfer #(
   parameter int WIDTH = 8
) (
   // source domain
   input  wire logic             src_clk,
   input  wire logic [WIDTH-1:0] src_data,
   // destination domain
   input  wire logic             dst_clk,
   output logic      [WIDTH-1:0] dst_data,
   // reset
   input  wire logic             reset
);
   import asfc_pkg::*;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("asfc_word_xfer: WIDTH must be at least 1");
      end
   endgenerate

   logic [WIDTH-1:0] hold_r;
   logic             req_r;
   logic             ack_r;
   logic [2:0]       ack_sync_r;
   logic [2:0]       req_sync_r;

   // ----------------------------------------
   // source: capture word, toggle request
   // ----------------------------------------
   wire src_idle = (ack_sync_r[1] == ack_sync_r[2]) && (ack_sync_r[2] == req_r);

   always_ff @(posedge src_clk or posedge reset) begin
      if (reset) begin
         ack_sync_r <= 3'h0;
         hold_r     <= '0;
         req_r      <= 1'b0;
      end else begin
         ack_sync_r <= {ack_sync_r[1:0], ack_r};
         if (src_idle) begin
            hold_r <= src_data;
            req_r  <= ~req_r;
         end
      end
   end

   // ----------------------------------------
   // destination: take word once request settles
   // ----------------------------------------
   wire dst_take = (req_sync_r[1] == req_sync_r[2]) && (req_sync_r[2] != ack_r);

   always_ff @(posedge dst_clk or posedge reset) begin
      if (reset) begin
         req_sync_r <= 3'h0;
         ack_r      <= 1'b0;
         dst_data   <= '0;
      end else begin
         req_sync_r <= {req_sync_r[1:0], req_r};
         if (dst_take) begin
            dst_data <= hold_r;
            ack_r    <= req_sync_r[2];
         end
      end
   end

endmodule

/* File: tb/asfc_host_model.sv */
`timescale 1ns/1ps
module asfc_host_model (
   // link pins
   output logic            link_clk,
   output logic            cs_n,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // reset
   input  wire logic       reset
);
   logic run;

   initial begin
      link_clk = 1'b0;
      run = 1'b0;
      cs_n = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // link clock stands still outside frames, except while reset is high
   always begin
      #32;
      if (run || reset) begin
         link_clk = ~link_clk;
      end
   end

   // one frame: n bytes from address a, reads shifted in msb first
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd,
                       input int n, output logic [55:0] d);
      d = '0;
      run = 1'b1;
      cs_n = 1'b0;
      // lead-in lets the status snapshot refresh across domains
      repeat (12) @(posedge link_clk);
      #1;
      reg_addr = a;
      reg_wr = w;
      reg_rd = !w;
      reg_wdata = wd;
      for (int i = 1; i <= n; i++) begin
         @(posedge link_clk);
         #1;
         if (i < n) begin
            reg_addr = a + 8'(i);
         end else begin
            reg_wr = 1'b0;
            reg_rd = 1'b0;
         end
         @(negedge link_clk);
         d = {d[47:0], reg_rdata};
      end
      // hold select so the read count reaches the core first
      repeat (8) @(posedge link_clk);
      #1;
      // chip select released between buffer reads
      cs_n = 1'b1;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
      repeat (12) @(posedge link_clk);
      run = 1'b0;
      // gap before the next buffer or status read
      #(asfc_pkg::HOST_GAP_NS);
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import asfc_pkg::*;

   typedef struct {
      logic [7:0] ctrl;
      int         n;
      int         lvl;
      logic       wm;
      logic       ovr;
      int         first;
   } asfc_row_type;

   logic                core_clk;
   logic                reset;
   logic                smp_valid;
   logic [SAMPLE_W-1:0] smp_data;
   logic                irq_out_a;
   logic                irq_out_b;
   logic                link_clk;
   logic                cs_n;
   logic [7:0]          reg_addr;
   logic                reg_wr;
   logic                reg_rd;
   logic [7:0]          reg_wdata;
   logic [7:0]          reg_rdata;
   logic                watermark;
   logic                overrun;
   logic                data_ready;
   logic [LEVEL_W-1:0]  level;
   logic [55:0]         rd;
   logic [47:0]         e;
   int                  miscompares;
   int                  num_checks;
   int                  cycles;
   int                  lv;
   int                  thr;
   asfc_row_type        rows [6] = '{
      '{8'h05, 3, 0, 1'b0, 1'b1, 2},
      '{8'h50, 16, 16, 1'b1, 1'b0, 0},
      '{8'h54, 40, 32, 1'b1, 1'b1, 0},
      '{8'h9F, 40, 32, 1'b1, 1'b1, 8},
      '{8'h88, 5, 5, 1'b0, 1'b0, 0},
      '{8'hC4, 33, 32, 1'b1, 1'b1, 1}};

   asfc_sample_buffer #(.DEPTH_P(DEPTH)) dut_u (
      .core_clk(core_clk), .reset(reset), .smp_valid(smp_valid), .smp_data(smp_data),
      .irq_out_a(irq_out_a), .irq_out_b(irq_out_b), .link_clk(link_clk), .cs_n(cs_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .watermark(watermark), .overrun(overrun),
      .data_ready(data_ready), .level(level));

   asfc_host_model host_u (
      .link_clk(link_clk), .cs_n(cs_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reset(reset));

   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [47:0] sample_of(input int r, input int i);
      return {8'(r), 8'h5A, 16'(i), 16'(i) ^ 16'hA5A5};
   endfunction

   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic push(input int r, input int i);
      @(negedge core_clk);
      smp_valid = 1'b1;
      smp_data = sample_of(r, i);
      @(negedge core_clk);
      smp_valid = 1'b0;
   endtask

   task automatic pulse(input logic b);
      @(negedge core_clk);
      irq_out_a = !b;
      irq_out_b = b;
      @(negedge core_clk);
      irq_out_a = 1'b0;
      irq_out_b = 1'b0;
   endtask

   task automatic flags(input int l, input logic wm, input logic ovr, input logic dr = 1'b0);
      repeat (3) @(negedge core_clk);
      chk(56'(level), 56'(l));
      chk(56'(watermark), 56'(wm));
      chk(56'(overrun), 56'(ovr));
      chk(56'(data_ready), 56'((l != 0) || dr));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host_u.xfer(a, 1'b1, v, 1, rd);
   endtask

   task automatic rdn(input logic [7:0] a, input int n);
      host_u.xfer(a, 1'b0, 8'h00, n, rd);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      smp_valid = 1'b0;
      smp_data = '0;
      irq_out_a = 1'b0;
      irq_out_b = 1'b0;
      miscompares = 0;
      num_checks = 0;
      cycles = 0;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      flags(0, 1'b1, 1'b0);
      rdn(ADDR_BUF_CTRL, 1);
      chk(rd, 56'(CTRL_RESET));
      rdn(ADDR_BUF_STATUS, 1);
      chk(rd, 56'h0);
      rdn(8'h10, 1);
      chk(rd, 56'h0);
      $display("test reset done");
      for (int r = 0; r < 6; r++) begin
         wr(ADDR_BUF_CTRL, 8'h00);
         wr(ADDR_BUF_CTRL, rows[r].ctrl);
         for (int i = 0; i < rows[r].n; i++) begin
            push(r, i);
         end
         flags(rows[r].lvl, rows[r].wm, rows[r].ovr, rows[r].ctrl[7:6] == MODE_BYPASS);
         rdn(ADDR_BUF_STATUS, 1);
         chk(rd, 56'(rows[r].lvl));
         rdn(ADDR_AXIS_FIRST, 6);
         chk(rd, 56'(sample_of(r, rows[r].first)));
         lv = (rows[r].lvl > 0) ? rows[r].lvl - 1 : 0;
         thr = int'(rows[r].ctrl[4:0]);
         flags(lv, rows[r].ctrl[7:6] != MODE_BYPASS && lv >= thr, 1'b0);
         $display("test row %0d done", r);
      end
      // trigger capture, source b, keep 4
      wr(ADDR_BUF_CTRL, 8'h04);
      wr(ADDR_BUF_CTRL, 8'hE4);
      for (int i = 0; i < 10; i++) begin
         push(7, i);
      end
      pulse(1'b0);
      flags(10, 1'b1, 1'b0);
      pulse(1'b1);
      #(HOST_GAP_NS);
      flags(4, 1'b1, 1'b0);
      rdn(ADDR_BUF_STATUS, 1);
      chk(rd, 56'h84);
      rdn(ADDR_AXIS_FIRST, 6);
      chk(rd, 56'(sample_of(7, 6)));
      pulse(1'b1);
      for (int i = 0; i < 40; i++) begin
         push(7, 10 + i);
      end
      flags(32, 1'b1, 1'b1);
      rdn(ADDR_AXIS_FIRST, 6);
      chk(rd, 56'(sample_of(7, 7)));
      wr(ADDR_BUF_CTRL, 8'h04);
      repeat (3) @(negedge core_clk);
      chk(56'(level), 56'h0);
      wr(ADDR_BUF_CTRL, 8'hE4);
      rdn(ADDR_BUF_STATUS, 1);
      chk(rd, 56'h0);
      for (int i = 0; i < 6; i++) begin
         push(9, i);
      end
      pulse(1'b1);
      #(HOST_GAP_NS);
      flags(4, 1'b1, 1'b0);
      $display("test trigger done");
      // single byte pop, then pop by address step
      wr(ADDR_BUF_CTRL, 8'h00);
      wr(ADDR_BUF_CTRL, 8'h9F);
      for (int i = 0; i < 3; i++) begin
         push(8, i);
      end
      e = sample_of(8, 0);
      rdn(8'h34, 1);
      chk(rd, 56'(e[31:24]));
      rdn(ADDR_AXIS_FIRST, 7);
      chk(rd, {sample_of(8, 1), 8'h9F});
      flags(1, 1'b0, 1'b0);
      $display("test pop done");
      test_done();
   end
endmodule
